// [rtl/bsc_pkg.sv]
package bsc_pkg;

	// ************************************************************
	// Widths and flag positions
	// ************************************************************
	localparam int PC_W = 22;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ************************************************************
	// Cycle counts
	// ************************************************************
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_REL_JUMP = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
	localparam logic [2:0] CYC_REL_CALL = 3'h3;
	localparam logic [2:0] CYC_PTR_CALL = 3'h3;
	localparam logic [2:0] CYC_ABS_CALL = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
	localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
	localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
	// Cycle in which popped stack data is valid (one after the pop)
	localparam logic [2:0] STEP_POP_DATA = 3'h2;

	// ************************************************************
	// Opcode masks and patterns
	// ************************************************************
	localparam logic [15:0] M_REL_JUMP = 16'hF000;
	localparam logic [15:0] P_REL_JUMP = 16'hC000;
	localparam logic [15:0] M_REL_CALL = 16'hF000;
	localparam logic [15:0] P_REL_CALL = 16'hD000;
	localparam logic [15:0] M_FIXED = 16'hFFFF;
	localparam logic [15:0] P_PTR_CALL = 16'h9509;
	localparam logic [15:0] P_SUB_RET = 16'h9508;
	localparam logic [15:0] P_INT_RET = 16'h9518;
	localparam logic [15:0] M_ABS = 16'hFE0E;
	localparam logic [15:0] P_ABS_JUMP = 16'h940C;
	localparam logic [15:0] P_ABS_CALL = 16'h940E;
	localparam logic [15:0] M_REG_OP = 16'hFC00;
	localparam logic [15:0] P_CMP_SKIP = 16'h1000;
	localparam logic [15:0] P_CMP = 16'h1400;
	localparam logic [15:0] P_CMP_CARRY = 16'h0400;
	localparam logic [15:0] M_CMP_IMM = 16'hF000;
	localparam logic [15:0] P_CMP_IMM = 16'h3000;
	localparam logic [15:0] M_REG_BIT = 16'hFE08;
	localparam logic [15:0] P_SKIP_REG_CLR = 16'hFC00;
	localparam logic [15:0] P_SKIP_REG_SET = 16'hFE00;
	localparam logic [15:0] M_IO_BIT = 16'hFF00;
	localparam logic [15:0] P_SKIP_IO_CLR = 16'h9900;
	localparam logic [15:0] P_SKIP_IO_SET = 16'h9B00;
	localparam logic [15:0] M_BRANCH = 16'hFC00;
	localparam logic [15:0] P_BR_SET = 16'hF000;
	localparam logic [15:0] P_BR_CLR = 16'hF400;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [PC_W-1:0] RST_PC = 22'h000000;
	localparam logic [7:0] RST_FLAGS = 8'h00;

	typedef enum {ST_IDLE, ST_BUSY} bsc_state_t;
	typedef enum {OP_NONE, OP_JUMP, OP_CALL, OP_RET, OP_CMP, OP_SKIP, OP_BRANCH} bsc_op_t;

endpackage

// [rtl/bsc_branch_skip_control.sv]
`timescale 1ns/1ns

// Contract
// - Pointer call: push return, PC gets Z, 3 cycles
// - Compare-skip-equal: skip on match, 1/2/3 cycles
// - Compares subtract, update flags, store nothing, 1 cycle
// - Skip when register bit clear, 1/2/3 cycles
// - Skip when register bit set, 1/2/3 cycles
// - Skip on I/O bit clear or set
// - Branch when selected flag set: PC+k+1
// - Branch when selected flag clear, 1/2 cycles
// - Equal/not-equal branch on zero flag
// - Carry set/clear branch on carry flag
// - Same-higher and lower alias carry branches
// - Minus/plus branch on negative flag
// - Signed greater-equal taken when N xor V zero
// - Signed less-than taken when N xor V one
// - Half-carry branches on half-carry flag
// - T-bit branches on T flag
// - Overflow-set branch, flags unchanged
// - Relative jump PC+k+1 in 2 cycles
module bsc_branch_skip_control (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic INSTR_VALID_IN,
	input wire logic [15:0] INSTR_IN,
	input wire logic [15:0] EXT_WORD_IN,
	input wire logic NEXT_TWO_WORD_IN,
	input wire logic [bsc_pkg::PC_W-1:0] PC_IN,
	input wire logic [7:0] RD_VAL_IN,
	input wire logic [7:0] RR_VAL_IN,
	input wire logic [7:0] IO_VAL_IN,
	input wire logic [15:0] Z_PTR_IN,
	input wire logic [7:0] STATUS_IN,
	input wire logic [bsc_pkg::PC_W-1:0] STACK_RDATA_IN,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic PC_LOAD_OUT,
	output logic [bsc_pkg::PC_W-1:0] PC_TARGET_OUT,
	output logic STATUS_WE_OUT,
	output logic [7:0] STATUS_OUT,
	output logic STACK_PUSH_OUT,
	output logic STACK_POP_OUT,
	output logic [bsc_pkg::PC_W-1:0] STACK_WDATA_OUT
);

	// ************************************************************
	// Helper functions
	// ************************************************************
	function automatic logic op_match(input logic [15:0] word, input logic [15:0] mask,
		input logic [15:0] pat);
		op_match = (word & mask) == pat;
	endfunction

	// Index 4 is the sign flag; it is formed from N and V directly so a stale S bit cannot
	// misroute a signed branch.
	function automatic logic flag_sel(input logic [7:0] flags, input logic [2:0] idx);
		if (idx == 3'(bsc_pkg::FLAG_S)) begin
			flag_sel = flags[bsc_pkg::FLAG_N] ^ flags[bsc_pkg::FLAG_V];
		end else begin
			flag_sel = flags[idx];
		end
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	bsc_pkg::bsc_state_t state;
	bsc_pkg::bsc_op_t op;
	logic [2:0] step;
	logic [2:0] total;
	logic [bsc_pkg::PC_W-1:0] target;
	logic load_pend;
	logic [7:0] flags_pend;
	logic flags_we_pend;

	bsc_pkg::bsc_op_t next_op;
	logic [2:0] next_total;
	logic [bsc_pkg::PC_W-1:0] next_target;
	logic [bsc_pkg::PC_W-1:0] next_ret;
	logic next_load;
	logic next_flags_we;
	logic [7:0] next_flags;
	logic accept;
	logic finish;

	logic [bsc_pkg::PC_W-1:0] rel_short;
	logic [bsc_pkg::PC_W-1:0] rel_long;
	logic [bsc_pkg::PC_W-1:0] skip_target;
	logic [2:0] skip_cycles;
	logic [7:0] sub_b;
	logic sub_cin;
	logic [8:0] diff;
	logic [7:0] res;

	assign BUSY_OUT = (state == bsc_pkg::ST_BUSY);
	assign accept = INSTR_VALID_IN && (state == bsc_pkg::ST_IDLE) && (next_op != bsc_pkg::OP_NONE);
	assign finish = (state == bsc_pkg::ST_BUSY) && (step == total - 3'h1);

	// Offsets are sign-extended; the +1 makes the target relative to the following word
	assign rel_short = PC_IN + {{(bsc_pkg::PC_W-7){INSTR_IN[9]}}, INSTR_IN[9:3]} + 22'h000001;
	assign rel_long = PC_IN + {{(bsc_pkg::PC_W-12){INSTR_IN[11]}}, INSTR_IN[11:0]} + 22'h000001;
	// Skip length depends on the size of the word being stepped over
	assign skip_target = PC_IN + (NEXT_TWO_WORD_IN ? 22'h000003 : 22'h000002);
	assign skip_cycles = NEXT_TWO_WORD_IN ? bsc_pkg::CYC_SKIP_TWO : bsc_pkg::CYC_SKIP_ONE;

	// ************************************************************
	// Compare arithmetic
	// ************************************************************
	always_comb begin
		sub_b = op_match(INSTR_IN, bsc_pkg::M_CMP_IMM, bsc_pkg::P_CMP_IMM) ?
			{INSTR_IN[11:8], INSTR_IN[3:0]} : RR_VAL_IN;
		sub_cin = op_match(INSTR_IN, bsc_pkg::M_REG_OP, bsc_pkg::P_CMP_CARRY) &&
			STATUS_IN[bsc_pkg::FLAG_C];
		diff = {1'b0, RD_VAL_IN} - {1'b0, sub_b} - {8'h00, sub_cin};
		res = diff[7:0];
	end

	// ************************************************************
	// Decode
	// ************************************************************
	always_comb begin
		next_op = bsc_pkg::OP_NONE;
		next_total = bsc_pkg::CYC_ONE;
		next_target = PC_IN;
		next_ret = PC_IN + 22'h000001;
		next_load = 1'b0;
		next_flags_we = 1'b0;
		next_flags = STATUS_IN;
		if (op_match(INSTR_IN, bsc_pkg::M_REL_JUMP, bsc_pkg::P_REL_JUMP)) begin
			next_op = bsc_pkg::OP_JUMP;
			next_total = bsc_pkg::CYC_REL_JUMP;
			next_target = rel_long;
			next_load = 1'b1;
		end else if (op_match(INSTR_IN, bsc_pkg::M_REL_CALL, bsc_pkg::P_REL_CALL)) begin
			next_op = bsc_pkg::OP_CALL;
			next_total = bsc_pkg::CYC_REL_CALL;
			next_target = rel_long;
			next_load = 1'b1;
		end else if (op_match(INSTR_IN, bsc_pkg::M_FIXED, bsc_pkg::P_PTR_CALL)) begin
			next_op = bsc_pkg::OP_CALL;
			next_total = bsc_pkg::CYC_PTR_CALL;
			next_target = {6'h00, Z_PTR_IN};
			next_load = 1'b1;
		end else if (op_match(INSTR_IN, bsc_pkg::M_ABS, bsc_pkg::P_ABS_JUMP) ||
			op_match(INSTR_IN, bsc_pkg::M_ABS, bsc_pkg::P_ABS_CALL)) begin
			next_target = {INSTR_IN[8:4], INSTR_IN[0], EXT_WORD_IN};
			next_load = 1'b1;
			next_ret = PC_IN + 22'h000002;
			if (INSTR_IN[1]) begin
				next_op = bsc_pkg::OP_CALL;
				next_total = bsc_pkg::CYC_ABS_CALL;
			end else begin
				next_op = bsc_pkg::OP_JUMP;
				next_total = bsc_pkg::CYC_ABS_JUMP;
			end
		end else if (op_match(INSTR_IN, bsc_pkg::M_FIXED, bsc_pkg::P_SUB_RET) ||
			op_match(INSTR_IN, bsc_pkg::M_FIXED, bsc_pkg::P_INT_RET)) begin
			next_op = bsc_pkg::OP_RET;
			next_total = bsc_pkg::CYC_RETURN;
			next_load = 1'b1;
			next_flags_we = INSTR_IN[4];
			next_flags[bsc_pkg::FLAG_I] = 1'b1;
		end else if (op_match(INSTR_IN, bsc_pkg::M_REG_OP, bsc_pkg::P_CMP) ||
			op_match(INSTR_IN, bsc_pkg::M_REG_OP, bsc_pkg::P_CMP_CARRY) ||
			op_match(INSTR_IN, bsc_pkg::M_CMP_IMM, bsc_pkg::P_CMP_IMM)) begin
			next_op = bsc_pkg::OP_CMP;
			next_flags_we = 1'b1;
			next_flags[bsc_pkg::FLAG_Z] = (res == 8'h00) &&
				(!sub_cin && !op_match(INSTR_IN, bsc_pkg::M_REG_OP, bsc_pkg::P_CMP_CARRY) ||
				STATUS_IN[bsc_pkg::FLAG_Z]);
			next_flags[bsc_pkg::FLAG_N] = res[7];
			next_flags[bsc_pkg::FLAG_V] = (RD_VAL_IN[7] & ~sub_b[7] & ~res[7]) |
				(~RD_VAL_IN[7] & sub_b[7] & res[7]);
			next_flags[bsc_pkg::FLAG_S] = res[7] ^ next_flags[bsc_pkg::FLAG_V];
			next_flags[bsc_pkg::FLAG_C] = (~RD_VAL_IN[7] & sub_b[7]) | (sub_b[7] & res[7]) |
				(res[7] & ~RD_VAL_IN[7]);
			next_flags[bsc_pkg::FLAG_H] = (~RD_VAL_IN[3] & sub_b[3]) | (sub_b[3] & res[3]) |
				(res[3] & ~RD_VAL_IN[3]);
		end else if (op_match(INSTR_IN, bsc_pkg::M_REG_OP, bsc_pkg::P_CMP_SKIP)) begin
			next_op = bsc_pkg::OP_SKIP;
			next_load = (RD_VAL_IN == RR_VAL_IN);
		end else if (op_match(INSTR_IN, bsc_pkg::M_REG_BIT, bsc_pkg::P_SKIP_REG_CLR) ||
			op_match(INSTR_IN, bsc_pkg::M_REG_BIT, bsc_pkg::P_SKIP_REG_SET)) begin
			next_op = bsc_pkg::OP_SKIP;
			next_load = (RR_VAL_IN[INSTR_IN[2:0]] == INSTR_IN[9]);
		end else if (op_match(INSTR_IN, bsc_pkg::M_IO_BIT, bsc_pkg::P_SKIP_IO_CLR) ||
			op_match(INSTR_IN, bsc_pkg::M_IO_BIT, bsc_pkg::P_SKIP_IO_SET)) begin
			next_op = bsc_pkg::OP_SKIP;
			next_load = (IO_VAL_IN[INSTR_IN[2:0]] == INSTR_IN[9]);
		end else if (op_match(INSTR_IN, bsc_pkg::M_BRANCH, bsc_pkg::P_BR_SET) ||
			op_match(INSTR_IN, bsc_pkg::M_BRANCH, bsc_pkg::P_BR_CLR)) begin
			// Named branches are fixed indices of these two forms, so one path serves all
			next_op = bsc_pkg::OP_BRANCH;
			next_target = rel_short;
			next_load = flag_sel(STATUS_IN, INSTR_IN[2:0]) != INSTR_IN[10];
			// Flag 1 Z, 0 C, 2 N, 4 N^V, 5 H, 6 T, 3 V all route through flag_sel
			next_total = next_load ? bsc_pkg::CYC_BR_TAKEN : bsc_pkg::CYC_ONE;
		end
		if (next_op == bsc_pkg::OP_SKIP) begin
			next_target = skip_target;
			next_total = next_load ? skip_cycles : bsc_pkg::CYC_ONE;
		end
	end

	// ************************************************************
	// Sequencing
	// ************************************************************
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			state <= bsc_pkg::ST_IDLE;
			op <= bsc_pkg::OP_NONE;
			step <= 3'h0;
			total <= 3'h0;
		end else if (accept) begin
			op <= next_op;
			step <= 3'h1;
			total <= next_total;
			state <= (next_total == bsc_pkg::CYC_ONE) ? bsc_pkg::ST_IDLE : bsc_pkg::ST_BUSY;
		end else if (finish) begin
			state <= bsc_pkg::ST_IDLE;
			step <= 3'h0;
		end else if (state == bsc_pkg::ST_BUSY) begin
			step <= step + 3'h1;
		end
	end

	// Pending results are held until the last cycle of the instruction
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			target <= bsc_pkg::RST_PC;
			load_pend <= 1'b0;
			flags_pend <= bsc_pkg::RST_FLAGS;
			flags_we_pend <= 1'b0;
		end else if (accept) begin
			target <= next_target;
			load_pend <= next_load;
			flags_pend <= next_flags;
			flags_we_pend <= next_flags_we;
		end else if (op == bsc_pkg::OP_RET && state == bsc_pkg::ST_BUSY &&
			step == bsc_pkg::STEP_POP_DATA) begin
			target <= STACK_RDATA_IN;
		end
	end

	// ************************************************************
	// Stack strobes
	// ************************************************************
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			STACK_PUSH_OUT <= 1'b0;
			STACK_POP_OUT <= 1'b0;
			STACK_WDATA_OUT <= bsc_pkg::RST_PC;
		end else begin
			STACK_PUSH_OUT <= accept && next_op == bsc_pkg::OP_CALL;
			STACK_POP_OUT <= accept && next_op == bsc_pkg::OP_RET;
			if (accept && next_op == bsc_pkg::OP_CALL) begin
				STACK_WDATA_OUT <= next_ret;
			end
		end
	end

	// ************************************************************
	// Completion outputs
	// ************************************************************
	// One-cycle instructions complete straight from accept; the rest on their last step.
	always_ff @(posedge MCLK_IN) begin
		if (!RST_N_IN) begin
			DONE_OUT <= 1'b0;
			PC_LOAD_OUT <= 1'b0;
			PC_TARGET_OUT <= bsc_pkg::RST_PC;
			STATUS_WE_OUT <= 1'b0;
			STATUS_OUT <= bsc_pkg::RST_FLAGS;
		end else if (accept && next_total == bsc_pkg::CYC_ONE) begin
			DONE_OUT <= 1'b1;
			PC_LOAD_OUT <= 1'b0;
			STATUS_WE_OUT <= next_flags_we;
			STATUS_OUT <= next_flags;
		end else if (finish) begin
			DONE_OUT <= 1'b1;
			PC_LOAD_OUT <= load_pend;
			PC_TARGET_OUT <= target;
			STATUS_WE_OUT <= flags_we_pend;
			STATUS_OUT <= flags_pend;
		end else begin
			DONE_OUT <= 1'b0;
			PC_LOAD_OUT <= 1'b0;
			STATUS_WE_OUT <= 1'b0;
		end
	end

endmodule // bsc_branch_skip_control

// [sim/bsc_stack_model.sv]
`timescale 1ns/1ns
// ************************************************************
// Return stack model
// ************************************************************
module bsc_stack_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic [bsc_pkg::PC_W-1:0] wdata_in,
	output logic [bsc_pkg::PC_W-1:0] rdata_out
);
	logic [bsc_pkg::PC_W-1:0] mem [0:7];
	logic [2:0] sp;
	// Data valid only the cycle after a pop; scrambled otherwise so stale reads show
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			sp <= 3'h0;
			rdata_out <= 22'h2AAAAA;
		end else if (push_in) begin
			mem[sp] <= wdata_in;
			sp <= sp + 3'h1;
			rdata_out <= ~rdata_out;
		end else if (pop_in) begin
			rdata_out <= mem[sp - 3'h1];
			sp <= sp - 3'h1;
		end else begin
			rdata_out <= ~rdata_out;
		end
	end
endmodule // bsc_stack_model

// [sim/bsc_sva.sv]
`timescale 1ns/1ns
// ************************************************************
// Flow-control checker
// ************************************************************
module bsc_sva (
	input wire logic MCLK_IN,
	input wire logic RST_N_IN,
	input wire logic INSTR_VALID_IN,
	input wire logic [15:0] INSTR_IN,
	input wire logic [bsc_pkg::PC_W-1:0] PC_IN,
	input wire logic [15:0] Z_PTR_IN,
	input wire logic [bsc_pkg::PC_W-1:0] STACK_RDATA_IN,
	input wire logic BUSY_OUT,
	input wire logic DONE_OUT,
	input wire logic PC_LOAD_OUT,
	input wire logic [bsc_pkg::PC_W-1:0] PC_TARGET_OUT,
	input wire logic STATUS_WE_OUT,
	input wire logic STACK_PUSH_OUT,
	input wire logic STACK_POP_OUT,
	input wire logic [bsc_pkg::PC_W-1:0] STACK_WDATA_OUT
);
	logic acc, f_rj, f_rc, f_pc, f_ac, f_rt, f_cmp, f_sk, f_br;
	logic [bsc_pkg::PC_W-1:0] rel;
	assign acc = INSTR_VALID_IN && !BUSY_OUT;
	assign f_rj = acc && (INSTR_IN & bsc_pkg::M_REL_JUMP) == bsc_pkg::P_REL_JUMP;
	assign f_rc = acc && (INSTR_IN & bsc_pkg::M_REL_CALL) == bsc_pkg::P_REL_CALL;
	assign f_pc = acc && INSTR_IN == bsc_pkg::P_PTR_CALL;
	assign f_ac = acc && (INSTR_IN & bsc_pkg::M_ABS) == bsc_pkg::P_ABS_CALL;
	assign f_rt = acc && (INSTR_IN == bsc_pkg::P_SUB_RET || INSTR_IN == bsc_pkg::P_INT_RET);
	assign f_cmp = acc && ((INSTR_IN & bsc_pkg::M_REG_OP) == bsc_pkg::P_CMP
		|| (INSTR_IN & bsc_pkg::M_REG_OP) == bsc_pkg::P_CMP_CARRY
		|| (INSTR_IN & bsc_pkg::M_CMP_IMM) == bsc_pkg::P_CMP_IMM);
	assign f_sk = acc && (INSTR_IN & bsc_pkg::M_REG_OP) == bsc_pkg::P_CMP_SKIP;
	assign f_br = acc && ((INSTR_IN & bsc_pkg::M_BRANCH) == bsc_pkg::P_BR_SET
		|| (INSTR_IN & bsc_pkg::M_BRANCH) == bsc_pkg::P_BR_CLR);
	assign rel = PC_IN + {{10{INSTR_IN[11]}}, INSTR_IN[11:0]} + 22'h000001;
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	chk_rel_jump_time: assert property (f_rj |=> BUSY_OUT ##1 DONE_OUT && PC_LOAD_OUT
		&& PC_TARGET_OUT == $past(rel, 2)) else $error("relative jump timing or target");
	chk_rel_call_push: assert property (f_rc |=> STACK_PUSH_OUT
		&& STACK_WDATA_OUT == $past(PC_IN) + 22'h000001
		##2 DONE_OUT && PC_LOAD_OUT && PC_TARGET_OUT == $past(rel, 3))
		else $error("relative call wrong");
	chk_ptr_call_z: assert property (f_pc |=> STACK_PUSH_OUT ##2 DONE_OUT && PC_LOAD_OUT
		&& PC_TARGET_OUT == {6'h00, $past(Z_PTR_IN, 3)}) else $error("pointer call wrong");
	chk_abs_call_four: assert property (f_ac |=> STACK_PUSH_OUT
		&& STACK_WDATA_OUT == $past(PC_IN) + 22'h000002 ##1 BUSY_OUT[*2] ##1 DONE_OUT)
		else $error("absolute call wrong");
	chk_return_pop: assert property (f_rt |=> STACK_POP_OUT ##3 DONE_OUT && PC_LOAD_OUT
		&& PC_TARGET_OUT == $past(STACK_RDATA_IN, 2)) else $error("return wrong");
	chk_cmp_one_cycle: assert property (f_cmp |=> DONE_OUT && STATUS_WE_OUT
		&& !PC_LOAD_OUT && !BUSY_OUT) else $error("compare not single cycle");
	chk_skip_equal_len: assert property (f_sk |=> (DONE_OUT && !PC_LOAD_OUT)
		or (BUSY_OUT ##1 DONE_OUT && PC_LOAD_OUT && PC_TARGET_OUT == $past(PC_IN, 2) + 22'h000002)
		or (BUSY_OUT[*2] ##1 DONE_OUT && PC_TARGET_OUT == $past(PC_IN, 3) + 22'h000003))
		else $error("compare skip wrong");
	chk_branch_cost: assert property (f_br |=> (DONE_OUT && !PC_LOAD_OUT)
		or (BUSY_OUT ##1 DONE_OUT && PC_LOAD_OUT)) else $error("branch cost wrong");
	chk_branch_flags_kept: assert property (f_br |=> !STATUS_WE_OUT && !STACK_PUSH_OUT
		&& !STACK_POP_OUT) else $error("branch touched flags or stack");
	cover property (f_rt ##4 STATUS_WE_OUT);
	cover property (f_sk ##3 PC_LOAD_OUT);
	cover property (f_br ##2 PC_LOAD_OUT);
endmodule // bsc_sva

bind bsc_branch_skip_control bsc_sva i_sva (.*);

// [sim/bsc_branch_skip_control_tb.sv]
`timescale 1ns/1ns
// ************************************************************
// Testbench
// ************************************************************
module bsc_branch_skip_control_tb;
	logic clk = 0, rst_n = 0, vld = 0, two = 0, s_two = 0;
	logic [15:0] ins = 0, ext = 0, z = 0, s_z = 0;
	logic [21:0] pc = 0;
	logic [7:0] rd = 0, rr = 0, io = 0, st = 0, s_rd = 0, s_rr = 0, s_io = 0, s_st = 0;
	logic busy, done, pload, stwe, push, pop;
	logic [21:0] tgt, wdat, rdat;
	logic [7:0] sto, pat [0:2] = '{8'h46, 8'hB1, 8'h08};
	logic fb, tk;
	int bad_count = 0, checked = 0, cyc = 0, n;
	bsc_branch_skip_control i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld),
		.INSTR_IN(ins), .EXT_WORD_IN(ext), .NEXT_TWO_WORD_IN(two), .PC_IN(pc),
		.RD_VAL_IN(rd), .RR_VAL_IN(rr), .IO_VAL_IN(io), .Z_PTR_IN(z), .STATUS_IN(st),
		.STACK_RDATA_IN(rdat), .BUSY_OUT(busy), .DONE_OUT(done), .PC_LOAD_OUT(pload),
		.PC_TARGET_OUT(tgt), .STATUS_WE_OUT(stwe), .STATUS_OUT(sto),
		.STACK_PUSH_OUT(push), .STACK_POP_OUT(pop), .STACK_WDATA_OUT(wdat));
	bsc_stack_model i_stack (.clk_in(clk), .rst_n_in(rst_n), .push_in(push), .pop_in(pop),
		.wdata_in(wdat), .rdata_out(rdat));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			stop_test();
		end
	end
	task stop_test;
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Operands ride along with the offer so they change only on the clock edge
	task run(input logic [15:0] i, e, input logic [21:0] p, input int xn, input logic xl,
		input logic [21:0] xt);
		@(posedge clk);
		ins <= i; ext <= e; pc <= p; rd <= s_rd; rr <= s_rr; io <= s_io;
		st <= s_st; z <= s_z; two <= s_two; vld <= 1;
		@(posedge clk);
		vld <= 0;
		for (n = 1; n < 6; n++) begin
			#1;
			if (done === 1'b1) break;
			@(posedge clk);
		end
		chk(n, xn);
		chk(pload, xl);
		if (xl) chk(tgt, xt);
	endtask
	function logic [7:0] fl(input logic [7:0] d, r, input logic ci, cz, input logic [7:0] s);
		logic [7:0] q;
		logic v, h, c;
		q = d - r - ci;
		v = (d[7] & ~r[7] & ~q[7]) | (~d[7] & r[7] & q[7]);
		h = (~d[3] & r[3]) | (r[3] & q[3]) | (q[3] & ~d[3]);
		c = (~d[7] & r[7]) | (r[7] & q[7]) | (q[7] & ~d[7]);
		return {s[7:6], h, q[7] ^ v, v, q[7], (q == 8'h00) & cz, c};
	endfunction
	task cmp1(input logic [15:0] i, input logic [7:0] d, r, s, e);
		s_rd = d; s_rr = r; s_st = s;
		run(i, 16'h0000, 22'h000000, 1, 0, 22'h000000);
		chk(stwe, 1);
		chk(sto, e);
	endtask
	task sk(input logic [15:0] i, input logic hit);
		for (int t = 0; t < 2; t++) begin
			s_two = t;
			run(i, 16'h0000, 22'h000050, hit ? 2 + t : 1, hit, 22'h000052 + t);
		end
	endtask
	task t_flow;
		run(16'hC005, 16'h0000, 22'h000100, 2, 1, 22'h000106);
		run(16'hCFFE, 16'h0000, 22'h000100, 2, 1, 22'h0000FF);
		run(16'h95FD, 16'h1234, 22'h000000, 3, 1, 22'h3F1234);
		s_z = 16'hABCD;
		run(16'hD010, 16'h0000, 22'h000200, 3, 1, 22'h000211);
		chk(wdat, 22'h000201);
		run(16'h940E, 16'h4000, 22'h000300, 4, 1, 22'h004000);
		run(16'h9509, 16'h0000, 22'h000400, 3, 1, 22'h00ABCD);
		run(16'h9508, 16'h0000, 22'h000000, 4, 1, 22'h000401);
		run(16'h9518, 16'h0000, 22'h000000, 4, 1, 22'h000302);
		chk({stwe, sto[7]}, 2'b11);
		run(16'h9508, 16'h0000, 22'h000000, 4, 1, 22'h000201);
		chk(stwe, 0);
		$display("flow test finished");
	endtask
	task t_cmp_skip;
		cmp1(16'h1400, 8'h10, 8'h10, 8'hC0, fl(8'h10, 8'h10, 0, 1, 8'hC0));
		cmp1(16'h1400, 8'h08, 8'h10, 8'h00, fl(8'h08, 8'h10, 0, 1, 8'h00));
		cmp1(16'h0400, 8'h80, 8'h7F, 8'h01, fl(8'h80, 8'h7F, 1, 0, 8'h01));
		cmp1(16'h0400, 8'h80, 8'h7F, 8'h03, fl(8'h80, 8'h7F, 1, 1, 8'h03));
		cmp1(16'h3800, 8'h7F, 8'h00, 8'h00, fl(8'h7F, 8'h80, 0, 1, 8'h00));
		s_rd = 8'h5A; s_rr = 8'h5A; s_io = 8'h80; s_st = 8'h00;
		sk(16'h1000, 1);
		s_rr = 8'h04;
		sk(16'h1000, 0);
		sk(16'hFC02, 0); sk(16'hFC03, 1);
		sk(16'hFE02, 1); sk(16'hFE03, 0);
		sk(16'h9987, 0); sk(16'h9980, 1); sk(16'h9B87, 1); sk(16'h9B80, 0);
		$display("compare and skip test finished");
	endtask
	// Index 4 follows N xor V, so patterns set S against it
	task t_branch;
		for (int p = 0; p < 3; p++) for (int s = 0; s < 8; s++) for (int c = 0; c < 2; c++) begin
			s_st = pat[p];
			fb = (s == 4) ? s_st[2] ^ s_st[3] : s_st[s];
			tk = c ? !fb : fb;
			run(16'(c ? 16'hF7E0 | s : 16'hF018 | s), 16'h0000, 22'h001000, tk ? 2 : 1, tk,
				c ? 22'h000FFD : 22'h001004);
			chk(stwe, 0);
		end
		$display("branch test finished");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		t_flow();
		t_cmp_skip();
		t_branch();
		stop_test();
	end
endmodule // bsc_branch_skip_control_tb
